// >>> acwd_pkg.sv
// Purpose: Shared constants and types for the converter control word decoder
// Assumes: Byte-wide host writes, low byte first
// Notes: All field positions and codes live here
package acwd_pkg;

    // ==========================================================
    // Word layout
    // ==========================================================
    localparam int CW_W = 14;
    localparam logic [1:0] ADDR_CTRL = 2'h3;
    localparam logic [CW_W-1:0] CW_RESET = 14'h0000;
    localparam logic [CW_W-1:0] CW_KEEP_MASK = 14'h03FF;
    localparam int B_PM_HI = 9;
    localparam int B_PM_LO = 8;
    localparam int B_RD_HI = 7;
    localparam int B_RD_LO = 6;
    localparam int B_RANGE = 5;
    localparam int B_CONV = 4;
    localparam int B_CMODE = 3;
    localparam int B_CS_HI = 2;
    localparam int B_CS_LO = 1;
    localparam int B_CSTART = 0;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int B_ADDR_HI = 15;
    localparam int B_ADDR_LO = 14;
    localparam logic [1:0] ADDR_TEST = 2'h1;
    localparam logic [1:0] ADDR_CAL = 2'h2;

    // ==========================================================
    // Read select codes
    // ==========================================================
    localparam logic [1:0] RD_RESULT = 2'h0;
    localparam logic [1:0] RD_TEST = 2'h1;
    localparam logic [1:0] RD_CAL = 2'h2;
    localparam logic [1:0] RD_STATUS = 2'h3;

    // ==========================================================
    // Calibration step sequence encodings (one hot step list)
    // ==========================================================
    localparam logic [2:0] STEP_DAC = 3'h4;
    localparam logic [2:0] STEP_GAIN = 3'h2;
    localparam logic [2:0] STEP_OFFS = 3'h1;
    localparam logic [2:0] STEPS_NONE = 3'h0;
    localparam logic [1:0] CS_FULL = 2'h0;
    localparam logic [1:0] CS_GAIN_OFFS = 2'h1;
    localparam logic [1:0] CS_OFFS = 2'h2;
    localparam logic [1:0] CS_GAIN = 2'h3;

    typedef enum logic [1:0] {ACWD_IDLE, ACWD_LOW_HELD} acwd_byte_e;

    typedef struct packed {
        logic [1:0] power_mode;
        logic [1:0] read_sel;
        logic range_bipolar;
        logic cal_system;
        logic [1:0] cal_select;
        logic [2:0] cal_steps;
        logic conv_go;
        logic cal_go;
    } acwd_ctrl_s;

    typedef struct packed {
        acwd_byte_e byte_st;
        logic [7:0] low_byte;
        logic [CW_W-1:0] cw;
        acwd_ctrl_s ctrl;
        logic cw_write;
    } acwd_state_s;

endpackage

// >>> acwd_decoder.sv
// Function
// RULE_01: Fourteen-bit write-only control word held.
// RULE_02: Only address bits 11 write the word.
// RULE_03: Reset clears every control word bit.
// RULE_04: Host writes zeros to bits 13-10.
// RULE_05: Bits 9-8 choose power mode.
// RULE_06: Bits 7-6 choose read source.
// RULE_07: Bit 5 picks unipolar or bipolar range.
// RULE_08: Bit 4 starts conversion, self-clears.
// RULE_09: Bit 3 picks self or system calibration.
// RULE_10: Start bit plus selects pick calibration.
// RULE_11: Calibration start bit clears on completion.
// RULE_12: Without start, selects address coefficient registers.
// RULE_13: Self 00 full, 01 gain then offset.
// RULE_14: Self 10 offset only, 11 gain only.
// RULE_15: System 00 full, 01 gain then offset.
// RULE_16: System 10 offset only, 11 gain only.
// RULE_17: Host sends low byte then high byte.
// RULE_18: Read select 00 result, 01 test, 10 cal, 11 status.
// RULE_19: Reserved upper bits ignored, treated zero.
//
// Purpose: Assemble host byte writes and decode the control word
// Assumes: wr_strobe one cycle per byte; done pulses from converter core
// Notes: Word itself is not readable; decoded fields are outputs
`timescale 1ns/1ps
module acwd_decoder
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic byte_restart,
    input wire logic conv_done,
    input wire logic cal_done,
    output acwd_pkg::acwd_ctrl_s ctrl,
    output logic cw_write
);

    // ==========================================================
    // State
    // ==========================================================
    acwd_pkg::acwd_state_s st_r;
    acwd_pkg::acwd_state_s st_nxt;

    // ==========================================================
    // Write targets of an assembled word
    // ==========================================================
    typedef enum logic [1:0] {TGT_NONE, TGT_TEST, TGT_CAL, TGT_CTRL} acwd_tgt_e;

    // ==========================================================
    // Address decode of the high byte
    // ==========================================================
    function automatic acwd_tgt_e target_of(input logic [1:0] addr);
        acwd_tgt_e t;
        if (addr == acwd_pkg::ADDR_CTRL)
        begin
            t = TGT_CTRL; // RULE_02
        end
        else if (addr == acwd_pkg::ADDR_CAL)
        begin
            t = TGT_CAL;
        end
        else if (addr == acwd_pkg::ADDR_TEST)
        begin
            t = TGT_TEST;
        end
        else
        begin
            t = TGT_NONE;
        end
        return t;
    endfunction

    // ==========================================================
    // Byte pairing
    // ==========================================================
    function automatic logic [acwd_pkg::WORD_W-1:0] join_bytes(
        input logic [acwd_pkg::BYTE_W-1:0] high,
        input logic [acwd_pkg::BYTE_W-1:0] low
    );
        return {high, low}; // RULE_17
    endfunction

    // ==========================================================
    // Reserved bits dropped
    // ==========================================================
    function automatic logic [acwd_pkg::CW_W-1:0] payload_of(
        input logic [acwd_pkg::WORD_W-1:0] word
    );
        return word[acwd_pkg::CW_W-1:0] & acwd_pkg::CW_KEEP_MASK; // RULE_19 RULE_04
    endfunction

    // ==========================================================
    // Calibration step list
    // ==========================================================
    function automatic logic [2:0] cal_steps_of(input logic [1:0] sel);
        logic [2:0] s;
        s = acwd_pkg::STEP_OFFS;
        case (sel)
            acwd_pkg::CS_FULL:
            begin
                s = acwd_pkg::STEP_DAC | acwd_pkg::STEP_GAIN
                    | acwd_pkg::STEP_OFFS; // RULE_13 RULE_15
            end
            acwd_pkg::CS_GAIN_OFFS:
            begin
                s = acwd_pkg::STEP_GAIN | acwd_pkg::STEP_OFFS; // RULE_13 RULE_15
            end
            acwd_pkg::CS_OFFS:
            begin
                s = acwd_pkg::STEP_OFFS; // RULE_14 RULE_16
            end
            default:
            begin
                s = acwd_pkg::STEP_GAIN; // RULE_14 RULE_16
            end
        endcase
        return s;
    endfunction

    // ==========================================================
    // Self-clearing start bits
    // ==========================================================
    function automatic logic [acwd_pkg::CW_W-1:0] retire_bits(
        input logic [acwd_pkg::CW_W-1:0] cw,
        input logic conv_end,
        input logic cal_end
    );
        logic [acwd_pkg::CW_W-1:0] r;
        r = cw;
        if (conv_end)
        begin
            r[acwd_pkg::B_CONV] = 1'b0; // RULE_08
        end
        if (cal_end)
        begin
            r[acwd_pkg::B_CSTART] = 1'b0; // RULE_11
        end
        return r;
    endfunction

    // ==========================================================
    // Field decode
    // ==========================================================
    function automatic acwd_pkg::acwd_ctrl_s decode_word(
        input logic [acwd_pkg::CW_W-1:0] cw
    );
        acwd_pkg::acwd_ctrl_s c;
        c = '0;
        c.power_mode = cw[acwd_pkg::B_PM_HI:acwd_pkg::B_PM_LO]; // RULE_05
        c.read_sel = cw[acwd_pkg::B_RD_HI:acwd_pkg::B_RD_LO]; // RULE_06 RULE_18
        c.range_bipolar = cw[acwd_pkg::B_RANGE]; // RULE_07
        c.cal_system = cw[acwd_pkg::B_CMODE]; // RULE_09
        c.cal_select = cw[acwd_pkg::B_CS_HI:acwd_pkg::B_CS_LO]; // RULE_12
        c.conv_go = cw[acwd_pkg::B_CONV]; // RULE_08
        c.cal_go = cw[acwd_pkg::B_CSTART]; // RULE_10
        if (c.cal_go)
        begin
            c.cal_steps = cal_steps_of(c.cal_select); // RULE_10
        end
        else
        begin
            c.cal_steps = acwd_pkg::STEPS_NONE; // RULE_12
        end
        return c;
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        logic [acwd_pkg::WORD_W-1:0] word;
        acwd_tgt_e tgt;
        word = join_bytes(wr_data, st_r.low_byte);
        tgt = target_of(word[acwd_pkg::B_ADDR_HI:acwd_pkg::B_ADDR_LO]);
        st_nxt = st_r;
        st_nxt.cw_write = 1'b0;
        st_nxt.cw = retire_bits(st_r.cw, conv_done, cal_done); // RULE_08 RULE_11
        if (byte_restart)
        begin
            st_nxt.byte_st = acwd_pkg::ACWD_IDLE;
        end
        else if (wr_strobe)
        begin
            case (st_r.byte_st)
                acwd_pkg::ACWD_IDLE:
                begin
                    st_nxt.low_byte = wr_data; // RULE_17
                    st_nxt.byte_st = acwd_pkg::ACWD_LOW_HELD;
                end
                default:
                begin
                    st_nxt.byte_st = acwd_pkg::ACWD_IDLE;
                    if (tgt == TGT_CTRL) // RULE_02
                    begin
                        st_nxt.cw = payload_of(word); // RULE_01
                        st_nxt.cw_write = 1'b1;
                    end
                end
            endcase
        end
        st_nxt.ctrl = decode_word(st_nxt.cw);
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0; // RULE_03
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign ctrl = st_r.ctrl;
    assign cw_write = st_r.cw_write;

endmodule

// >>> acwd_monitor.sv
// Purpose: Port assertions for the control word decoder
// Assumes: Registered ctrl and cw_write
// Notes: Bound after the module
`timescale 1ns/1ps
module acwd_monitor
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_strobe,
    input wire logic [7:0] wr_data,
    input wire logic conv_done,
    input wire logic cal_done,
    input acwd_pkg::acwd_ctrl_s ctrl,
    input wire logic cw_write
);
    localparam logic [11:0] STEPS = 12'h45F;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_rst; $fell(rst) |-> ctrl == '0; endproperty
    a_rst: assert property (p_rst) else $error("ctrl after reset");
    property p_addr; cw_write |-> $past(wr_strobe) && $past(wr_data[7:6]) == 2'h3; endproperty
    a_addr: assert property (p_addr) else $error("word address");
    property p_pulse; cw_write |=> !cw_write; endproperty
    a_pulse: assert property (p_pulse) else $error("cw_write width");
    property p_hold; !cw_write |-> $stable(ctrl.power_mode) && $stable(ctrl.read_sel)
        && $stable(ctrl.range_bipolar) && $stable(ctrl.cal_system); endproperty
    a_hold: assert property (p_hold) else $error("field moved");
    property p_start; $rose(ctrl.conv_go) || $rose(ctrl.cal_go) |-> cw_write; endproperty
    a_start: assert property (p_start) else $error("start source");
    property p_conv; conv_done && !wr_strobe && !cw_write |=> !ctrl.conv_go; endproperty
    a_conv: assert property (p_conv) else $error("conv clear");
    property p_cal; cal_done && !wr_strobe && !cw_write |=> !ctrl.cal_go; endproperty
    a_cal: assert property (p_cal) else $error("cal clear");
    property p_steps; ctrl.cal_go |-> ctrl.cal_steps == STEPS[ctrl.cal_select*3 +: 3]; endproperty
    a_steps: assert property (p_steps) else $error("cal steps");
    property p_idle; !ctrl.cal_go |-> ctrl.cal_steps == 3'h0; endproperty
    a_idle: assert property (p_idle) else $error("steps idle");
endmodule
bind acwd_decoder acwd_monitor u_mon (.sys_clk, .rst, .wr_strobe, .wr_data, .conv_done,
    .cal_done, .ctrl, .cw_write);

// >>> acwd_host.sv
// Purpose: Host byte writer
// Assumes: Bytes driven 1 ns after the edge
// Notes: Released data shows its inverse
`timescale 1ns/1ps
module acwd_host
(
    input wire logic sys_clk,
    output logic wr_strobe = 1'b0,
    output logic [7:0] wr_data = 8'h00
);
    task automatic put(input logic [7:0] b);
        @(posedge sys_clk);
        #1;
        wr_strobe = 1'b1;
        wr_data = b;
    endtask
    task automatic idle();
        @(posedge sys_clk);
        #1;
        wr_strobe = 1'b0;
        wr_data = ~wr_data;
    endtask
    task automatic wr(input logic [9:0] v, input logic [1:0] a);
        put(v[7:0]);
        put({a, 4'h0, v[9:8]});
        idle();
    endtask
endmodule

// >>> acwd_decoder_tb.sv
// Purpose: Self-checking bench for the decoder
// Assumes: Host model drives the byte port
// Notes: Random words from an LFSR seeded at 19
`timescale 1ns/1ps
module acwd_decoder_tb;
    logic sys_clk, rst, byte_restart, conv_done, cal_done, wr_strobe, cw_write;
    logic [7:0] wr_data;
    acwd_pkg::acwd_ctrl_s ctrl, cur;
    int error_cnt = 0;
    int checked = 0;
    logic [15:0] seed = 16'h0013;
    acwd_host host (.sys_clk, .wr_strobe, .wr_data);
    acwd_decoder DUT (.sys_clk, .rst, .wr_strobe, .wr_data, .byte_restart, .conv_done,
        .cal_done, .ctrl, .cw_write);
    function automatic acwd_pkg::acwd_ctrl_s exp_f(input logic [9:0] w);
        logic [11:0] t;
        t = 12'h45F;
        return '{w[9:8], w[7:6], w[5], w[3], w[2:1], w[0] ? t[w[2:1]*3 +: 3] : 3'h0, w[4], w[0]};
    endfunction
    task automatic chk(input acwd_pkg::acwd_ctrl_s e);
        checked++;
        if (ctrl !== e)
        begin
            error_cnt++;
            $display("Error ctrl expected %h seen %h", e, ctrl);
        end
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk_bit(input logic e, input logic s);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("Error cw_write expected %b seen %b", e, s);
        end
    endtask
    task automatic settle(input logic [9:0] w, input logic [1:0] a);
        chk_bit(a == 2'h3, cw_write);
        if (a == 2'h3)
            cur = exp_f(w);
        @(posedge sys_clk);
        #1;
        chk(cur);
        conv_done = 1'b1;
        @(posedge sys_clk);
        #1;
        conv_done = 1'b0;
        cur.conv_go = 1'b0;
        chk(cur);
        cal_done = 1'b1;
        @(posedge sys_clk);
        #1;
        cal_done = 1'b0;
        {cur.cal_steps, cur.cal_go} = 4'h0;
        chk(cur);
    endtask
    task automatic step(input logic [9:0] w, input logic [1:0] a);
        host.wr(w, a);
        settle(w, a);
    endtask
    task automatic final_report();
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #20000;
        error_cnt++;
        final_report();
    end
    initial
    begin
        {rst, byte_restart, conv_done, cal_done} = 4'h8;
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk('0);
        chk_bit(1'b0, cw_write);
        for (int i = 0; i < 8; i++)
            step({6'h00, i[2:0], 1'b1}, 2'h3);
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr_next(seed);
            step(seed[9:0], 2'h3);
        end
        for (int a = 0; a < 3; a++)
            step(10'h3FF, a[1:0]);
        host.put(8'h96);
        host.put({2'h3, 4'hF, 2'h2});
        host.idle();
        settle(10'h296, 2'h3);
        host.wr(10'h3FF, 2'h3);
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk('0);
        chk_bit(1'b0, cw_write);
        host.put(8'h5A);
        host.idle();
        byte_restart = 1'b1;
        @(posedge sys_clk);
        #1;
        byte_restart = 1'b0;
        step(10'h2C5, 2'h3);
        final_report();
    end
endmodule
